// *** src/mcr_pkg.sv ***
// package: register map, field positions and command codes of the control register bank
package mcr_pkg;
   localparam logic [15:0] ADDR_QUES_STATUS   = 16'h10B0;
   localparam logic [15:0] ADDR_FULL_STATUS   = 16'h10D0;
   localparam logic [15:0] ADDR_OUTEN_WR      = 16'h10F0;
   localparam logic [15:0] ADDR_OUTEN_RD      = 16'h1100;
   localparam logic [15:0] ADDR_MEAS_CURR     = 16'h2010;
   localparam logic [15:0] ADDR_MEAS_VOLT     = 16'h2020;
   localparam logic [15:0] ADDR_MEAS_PWR      = 16'h2030;
   localparam logic [15:0] ADDR_MODE_WR       = 16'h6030;
   localparam logic [15:0] ADDR_MODE_RD       = 16'h6040;
   localparam logic [15:0] ADDR_RECALL_WR     = 16'h8010;
   localparam logic [15:0] ADDR_GUARD_RD      = 16'h8020;
   localparam logic [15:0] ADDR_GUARD_WR      = 16'h8030;
   localparam logic [15:0] ADDR_SENSE_WR      = 16'h8060;
   localparam logic [15:0] ADDR_SENSE_RD      = 16'h8070;
   localparam logic [15:0] ADDR_PROTO_WR      = 16'h8080;
   localparam logic [15:0] ADDR_PROTO_RD      = 16'h8090;
   localparam logic [15:0] ADDR_ORIGIN_WR     = 16'h80A0;
   localparam logic [15:0] ADDR_ORIGIN_RD     = 16'h80B0;
   // 32-bit float settings: write address, read-back address
   localparam int          NUM_WIDE = 13;
   localparam logic [15:0] WIDE_WR [NUM_WIDE] = '{
      16'h3010, 16'h3030, 16'h3050, 16'h4010, 16'h4030, 16'h4050, 16'h4070,
      16'h5010, 16'h5030, 16'h5050, 16'h5090, 16'h50B0, 16'h50D0};
   localparam logic [15:0] WIDE_RD [NUM_WIDE] = '{
      16'h3020, 16'h3040, 16'h3060, 16'h4020, 16'h4040, 16'h4060, 16'h4080,
      16'h5020, 16'h5040, 16'h5060, 16'h50A0, 16'h50C0, 16'h50E0};
   localparam logic [3:0]  WIDE_IDX_W = 4'hD;
   localparam logic [7:0]  FC_READ     = 8'h03;
   localparam logic [7:0]  FC_WRITE1   = 8'h06;
   localparam logic [7:0]  FC_WRITE2   = 8'h10;
   localparam logic [7:0]  EXC_NONE    = 8'h00;
   localparam logic [7:0]  EXC_ADDRESS = 8'h02;
   localparam logic [7:0]  EXC_VALUE   = 8'h03;
   localparam logic [2:0]  CNT_ONE     = 3'h1;
   localparam logic [2:0]  CNT_TWO     = 3'h2;
   localparam logic [2:0]  CNT_FOUR    = 3'h4;
   localparam logic [15:0] REG_RESET   = 16'h0000;
   // questionable status bit positions
   localparam int Q_HARD_OV = 0;
   localparam int Q_SOFT_OC = 1;
   localparam int Q_SOFT_OV = 2;
   localparam int Q_SOFT_OP = 3;
   localparam int Q_HARD_OC = 4;
   localparam int Q_HARD_OT = 5;
   localparam int Q_SENSE   = 6;
   localparam int Q_REG_LO  = 7;
   localparam int Q_SOFT    = 11;
   localparam int Q_HARD    = 12;
   localparam int Q_ILOCK   = 13;
   localparam int Q_IPL     = 14;
   localparam int Q_UIF     = 15;
   typedef enum logic [1:0] {MCR_IDLE, MCR_READ, MCR_WRITE} mcr_op_e;
endpackage

// *** src/mcr_wide_if.sv ***
// interface: wide setting store port between bank and storage
`timescale 1ns/1ps
`default_nettype none
interface mcr_wide_if;
   logic        wr_en;
   logic [3:0]  wr_idx;
   logic [31:0] wr_data;
   logic [3:0]  rd_idx;
   logic [31:0] rd_data;
   modport bank (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
   modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// *** src/mcr_wide_store.sv ***
// storage for the thirty-two bit float settings, registered read
`timescale 1ns/1ps
`default_nettype none
module mcr_wide_store #(
   parameter int DEPTH = 13
) (
   input  wire logic clock_i,
   input  wire logic reset_n_i,
   mcr_wide_if.store port_s
);
   logic [31:0] mem [DEPTH];
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= 32'h0000_0000;
         end
      end else if (port_s.wr_en && 32'(port_s.wr_idx) < DEPTH) begin
         mem[port_s.wr_idx] <= port_s.wr_data;
      end
   end
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         port_s.rd_data <= 32'h0000_0000;
      end else if (32'(port_s.rd_idx) < DEPTH) begin
         port_s.rd_data <= mem[port_s.rd_idx];
      end else begin
         port_s.rd_data <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// *** src/mcr_bank.sv ***
// register bank answering decoded remote requests
// How it works
// - read returns addressed register's present value
// - write updates register then confirms
// - one value per request, one/two/four registers
// - settings have separate write and read addresses
// - questionable word at 0x10B0, two registers
// - questionable word read-only, live, never cleared
// - full status four registers, live, read-only
// - bits 0-6 are protection and trip flags
// - bits 7-10 show regulation state
// - bit 11 ORs soft faults
// - bit 12 ORs hard faults
// - bits 13-15 interlock, input loss, input fault
// - questionable word layout fixed, subset of full
// - measurements read-only at 0x2010/20/30
// - set-point write/read address pairs
// - trip threshold write/read address pairs
// - slew rates read back 0x10 higher
// - control mode 0x6030 write, 0x6040 read
// - 0x8010 write recalls defaults, no read
// - lock refuses configuration and set-point changes
// - sense configuration 0x8060/0x8070
// - protocol and origin selection pairs
// - function codes 0x03, 0x06, 0x10
// - most significant register first
// - exception 0x02 or 0x03 on bad requests
// - output enable 0x10F0 write, 0x1100 read
`timescale 1ns/1ps
`default_nettype none
module mcr_bank (
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   input  wire logic        req_valid_i,
   input  wire logic [7:0]  req_func_i,
   input  wire logic [15:0] req_addr_i,
   input  wire logic [15:0] req_count_i,
   input  wire logic [7:0]  req_bytes_i,
   input  wire logic [63:0] req_data_i,
   input  wire logic [15:0] hard_flags_i,
   input  wire logic [15:0] soft_flags_i,
   input  wire logic [3:0]  regulation_i,
   input  wire logic [63:0] full_status_i,
   input  wire logic [31:0] measured_current_i,
   input  wire logic [31:0] measured_voltage_i,
   input  wire logic [31:0] measured_power_i,
   output logic             rsp_valid_o,
   output logic [7:0]       rsp_exception_o,
   output logic [2:0]       rsp_count_o,
   output logic [63:0]      rsp_data_o,
   output logic             output_enable_o,
   output logic [15:0]      regulation_mode_o,
   output logic             change_guard_o,
   output logic [15:0]      sense_config_o,
   output logic [15:0]      protocol_select_o,
   output logic [15:0]      target_origin_o,
   output logic             defaults_recall_o
);
   mcr_wide_if wide ();
   mcr_wide_store #(.DEPTH(mcr_pkg::NUM_WIDE)) u_store (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .port_s    (wide.store)
   );

   // hard_flags_i: [0]=ov prot [1]=oc prot [2]=temp [3]=sense loss
   // soft_flags_i: [0]=oc trip [1]=ov trip [2]=op trip; [13..15] of hard: interlock, input loss, user input
   logic [31:0] questionable_status;
   always_comb begin
      questionable_status = 32'h0000_0000;
      questionable_status[mcr_pkg::Q_HARD_OV] = hard_flags_i[0];
      questionable_status[mcr_pkg::Q_SOFT_OC] = soft_flags_i[0];
      questionable_status[mcr_pkg::Q_SOFT_OV] = soft_flags_i[1];
      questionable_status[mcr_pkg::Q_SOFT_OP] = soft_flags_i[2];
      questionable_status[mcr_pkg::Q_HARD_OC] = hard_flags_i[1];
      questionable_status[mcr_pkg::Q_HARD_OT] = hard_flags_i[2];
      questionable_status[mcr_pkg::Q_SENSE]   = hard_flags_i[3];
      questionable_status[mcr_pkg::Q_REG_LO +: 4] = regulation_i;
      questionable_status[mcr_pkg::Q_SOFT] = |soft_flags_i[2:0];
      questionable_status[mcr_pkg::Q_HARD] = |hard_flags_i[3:0];
      questionable_status[mcr_pkg::Q_ILOCK] = hard_flags_i[13];
      questionable_status[mcr_pkg::Q_IPL]   = hard_flags_i[14];
      questionable_status[mcr_pkg::Q_UIF]   = hard_flags_i[15];
   end

   function automatic logic [4:0] wide_find(input logic [15:0] a, input logic rd);
      logic [4:0] r;
      r = 5'h1F;
      for (int i = 0; i < mcr_pkg::NUM_WIDE; i++) begin
         if ((rd ? mcr_pkg::WIDE_RD[i] : mcr_pkg::WIDE_WR[i]) == a) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // request decode
   logic [4:0]  wr_hit;
   logic [4:0]  rd_hit;
   logic [2:0]  need_cnt;
   logic        is_read_addr;
   logic        is_write_addr;
   logic        is_config;
   logic [7:0]  next_exc;
   logic [63:0] next_data;
   logic        do_write;
   always_comb begin
      wr_hit = wide_find(req_addr_i, 1'b0);
      rd_hit = wide_find(req_addr_i, 1'b1);
      is_read_addr = 1'b1;
      is_write_addr = 1'b0;
      is_config = 1'b1;
      need_cnt = mcr_pkg::CNT_ONE;
      next_data = 64'h0;
      case (req_addr_i)
         mcr_pkg::ADDR_QUES_STATUS: begin
            need_cnt = mcr_pkg::CNT_TWO;
            next_data = {32'h0, questionable_status};
         end
         mcr_pkg::ADDR_FULL_STATUS: begin
            need_cnt = mcr_pkg::CNT_FOUR;
            next_data = full_status_i;
         end
         mcr_pkg::ADDR_MEAS_CURR: begin
            need_cnt = mcr_pkg::CNT_TWO;
            next_data = {32'h0, measured_current_i};
         end
         mcr_pkg::ADDR_MEAS_VOLT: begin
            need_cnt = mcr_pkg::CNT_TWO;
            next_data = {32'h0, measured_voltage_i};
         end
         mcr_pkg::ADDR_MEAS_PWR: begin
            need_cnt = mcr_pkg::CNT_TWO;
            next_data = {32'h0, measured_power_i};
         end
         mcr_pkg::ADDR_OUTEN_RD: next_data = {63'h0, output_enable_o};
         mcr_pkg::ADDR_MODE_RD: next_data = {48'h0, regulation_mode_o};
         mcr_pkg::ADDR_GUARD_RD: next_data = {63'h0, change_guard_o};
         mcr_pkg::ADDR_SENSE_RD: next_data = {48'h0, sense_config_o};
         mcr_pkg::ADDR_PROTO_RD: next_data = {48'h0, protocol_select_o};
         mcr_pkg::ADDR_ORIGIN_RD: next_data = {48'h0, target_origin_o};
         mcr_pkg::ADDR_OUTEN_WR: begin
            is_read_addr = 1'b0;
            is_write_addr = 1'b1;
            is_config = 1'b0; // standby must stay reachable while locked
         end
         mcr_pkg::ADDR_GUARD_WR: begin
            is_read_addr = 1'b0;
            is_write_addr = 1'b1;
            is_config = 1'b0; // unlock must always pass
         end
         mcr_pkg::ADDR_MODE_WR, mcr_pkg::ADDR_RECALL_WR, mcr_pkg::ADDR_SENSE_WR,
         mcr_pkg::ADDR_PROTO_WR, mcr_pkg::ADDR_ORIGIN_WR: begin
            is_read_addr = 1'b0;
            is_write_addr = 1'b1;
         end
         default: begin
            if (wr_hit != 5'h1F) begin
               is_read_addr = 1'b0;
               is_write_addr = 1'b1;
               need_cnt = mcr_pkg::CNT_TWO;
            end else if (rd_hit != 5'h1F) begin
               need_cnt = mcr_pkg::CNT_TWO;
            end else begin
               is_read_addr = 1'b0;
            end
         end
      endcase
      // exception priority: count range, then address/function pairing
      next_exc = mcr_pkg::EXC_NONE;
      do_write = 1'b0;
      case (req_func_i)
         mcr_pkg::FC_READ: begin
            if (req_count_i == 16'h0 || req_count_i > 16'(mcr_pkg::CNT_FOUR)) begin
               next_exc = mcr_pkg::EXC_VALUE;
            end else if (!is_read_addr || req_count_i != 16'(need_cnt)) begin
               next_exc = mcr_pkg::EXC_ADDRESS;
            end
         end
         mcr_pkg::FC_WRITE1: begin
            if (!is_write_addr || need_cnt != mcr_pkg::CNT_ONE) begin
               next_exc = mcr_pkg::EXC_ADDRESS;
            end else begin
               do_write = 1'b1;
            end
         end
         mcr_pkg::FC_WRITE2: begin
            // byte count must be twice the register count
            if (req_count_i == 16'h0 || req_count_i > 16'(mcr_pkg::CNT_TWO) ||
                  {1'b0, req_bytes_i} != {req_count_i[7:0], 1'b0}) begin
               next_exc = mcr_pkg::EXC_VALUE;
            end else if (!is_write_addr || req_count_i != 16'(need_cnt)) begin
               next_exc = mcr_pkg::EXC_ADDRESS;
            end else begin
               do_write = 1'b1;
            end
         end
         default: next_exc = mcr_pkg::EXC_ADDRESS;
      endcase
   end

   // lock refuses configuration writes but still confirms them
   logic commit;
   assign commit = req_valid_i && do_write && !(change_guard_o && is_config);

   always_comb begin
      wide.wr_en = commit && wr_hit != 5'h1F;
      wide.wr_idx = wr_hit[3:0];
      wide.wr_data = req_data_i[31:0];
      wide.rd_idx = rd_hit[3:0];
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         output_enable_o <= 1'b0;
         regulation_mode_o <= mcr_pkg::REG_RESET;
         change_guard_o <= 1'b0;
         sense_config_o <= mcr_pkg::REG_RESET;
         protocol_select_o <= mcr_pkg::REG_RESET;
         target_origin_o <= mcr_pkg::REG_RESET;
      end else if (commit) begin
         case (req_addr_i)
            mcr_pkg::ADDR_OUTEN_WR: output_enable_o <= req_data_i[0];
            mcr_pkg::ADDR_MODE_WR: regulation_mode_o <= req_data_i[15:0];
            mcr_pkg::ADDR_GUARD_WR: change_guard_o <= req_data_i[0];
            mcr_pkg::ADDR_SENSE_WR: sense_config_o <= req_data_i[15:0];
            mcr_pkg::ADDR_PROTO_WR: protocol_select_o <= req_data_i[15:0];
            mcr_pkg::ADDR_ORIGIN_WR: target_origin_o <= req_data_i[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         defaults_recall_o <= 1'b0;
      end else begin
         defaults_recall_o <= commit && req_addr_i == mcr_pkg::ADDR_RECALL_WR;
      end
   end

   // answer one cycle after the request; wide read-back arrives from storage then
   logic        pend;
   logic        pend_wide;
   logic [7:0]  pend_exc;
   logic [2:0]  pend_cnt;
   logic [63:0] pend_data;
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pend <= 1'b0;
         pend_wide <= 1'b0;
         pend_exc <= mcr_pkg::EXC_NONE;
         pend_cnt <= 3'h0;
         pend_data <= 64'h0;
      end else begin
         pend <= req_valid_i;
         pend_wide <= req_func_i == mcr_pkg::FC_READ && rd_hit != 5'h1F;
         pend_exc <= next_exc;
         pend_cnt <= (next_exc == mcr_pkg::EXC_NONE) ? need_cnt : 3'h0;
         pend_data <= (req_func_i == mcr_pkg::FC_READ) ? next_data : req_data_i;
      end
   end

   assign rsp_valid_o = pend;
   assign rsp_exception_o = pend_exc;
   assign rsp_count_o = pend_cnt;
   assign rsp_data_o = (pend_wide && pend_exc == mcr_pkg::EXC_NONE) ? {32'h0, wide.rd_data} : pend_data;

   chk_answer_follows: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      req_valid_i |=> rsp_valid_o) else $error("request got no answer");
   chk_write_commits: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      req_valid_i && req_func_i == mcr_pkg::FC_WRITE1 && req_addr_i == mcr_pkg::ADDR_GUARD_WR
      && next_exc == mcr_pkg::EXC_NONE |=> change_guard_o == $past(req_data_i[0])) else $error("write lost");
   chk_lock_refuses: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      change_guard_o && req_valid_i && req_addr_i == mcr_pkg::ADDR_MODE_WR
      |=> $stable(regulation_mode_o)) else $error("locked write changed mode");
   chk_soft_or: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      questionable_status[mcr_pkg::Q_SOFT] == (|questionable_status[3:1])) else $error("soft or wrong");
   chk_hard_or: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      questionable_status[mcr_pkg::Q_HARD] == (questionable_status[0] | (|questionable_status[6:4])))
      else $error("hard or wrong");
   chk_wrong_dir: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      req_valid_i && req_func_i == mcr_pkg::FC_READ && req_addr_i == mcr_pkg::ADDR_RECALL_WR
      && req_count_i == 16'h1 |=> rsp_exception_o == mcr_pkg::EXC_ADDRESS) else $error("wrong direction taken");
   chk_count_range: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      req_valid_i && req_func_i == mcr_pkg::FC_WRITE2 && req_count_i > 16'h2
      |=> rsp_exception_o == mcr_pkg::EXC_VALUE && !$past(wide.wr_en)) else $error("bad count accepted");
   chk_recall_pulse: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      defaults_recall_o |=> !defaults_recall_o || $past(req_valid_i)) else $error("recall pulse stuck");
   chk_ques_live: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      req_valid_i && req_func_i == mcr_pkg::FC_READ && req_addr_i == mcr_pkg::ADDR_QUES_STATUS
      && req_count_i == 16'h2 |=> rsp_data_o[31:0] == $past(questionable_status)) else $error("status stale");
   chk_refusal_count: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      rsp_valid_o && rsp_exception_o != mcr_pkg::EXC_NONE |-> rsp_count_o == 3'h0) else $error("refusal with count");
   chk_locked_store: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      change_guard_o && req_valid_i && is_config |-> !wide.wr_en) else $error("locked setting stored");
endmodule
`default_nettype wire

// *** testbench/mcr_master_model.sv ***
// remote master model: issues one decoded request and collects its answer
`timescale 1ns/1ps
`default_nettype none
module mcr_master_model (
   input  wire logic        clock_i,
   output logic             req_valid_o,
   output logic [7:0]       req_func_o,
   output logic [15:0]      req_addr_o,
   output logic [15:0]      req_count_o,
   output logic [7:0]       req_bytes_o,
   output logic [63:0]      req_data_o,
   input  wire logic        rsp_valid_i,
   input  wire logic [7:0]  rsp_exception_i,
   input  wire logic [2:0]  rsp_count_i,
   input  wire logic [63:0] rsp_data_i
);
   initial begin
      req_valid_o = 1'b0;
      req_func_o  = 8'h00;
      req_addr_o  = 16'h0000;
      req_count_o = 16'h0000;
      req_bytes_o = 8'h00;
      req_data_o  = 64'h0;
   end
   // one value per request; count, bytes and function as the caller orders
   task automatic transact(input logic [7:0] func, input logic [15:0] addr, input logic [15:0] count,
                           input logic [7:0] bytes, input logic [63:0] data, output logic got,
                           output logic [7:0] exc, output logic [2:0] cnt, output logic [63:0] rdata);
      @(posedge clock_i);
      req_valid_o <= 1'b1;
      req_func_o  <= func;
      req_addr_o  <= addr;
      req_count_o <= count;
      req_bytes_o <= bytes;
      req_data_o  <= data;
      @(posedge clock_i);
      req_valid_o <= 1'b0;
      // released function, address and data must not keep the last value
      req_func_o  <= ~func;
      req_addr_o  <= ~addr;
      req_data_o  <= ~data;
      #1;
      got   = rsp_valid_i;
      exc   = rsp_exception_i;
      cnt   = rsp_count_i;
      rdata = rsp_data_i;
   endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [7:0] RD = mcr_pkg::FC_READ;
   localparam logic [7:0] W1 = mcr_pkg::FC_WRITE1;
   localparam logic [7:0] W2 = mcr_pkg::FC_WRITE2;
   localparam logic [7:0] OK = mcr_pkg::EXC_NONE;
   localparam logic [7:0] EA = mcr_pkg::EXC_ADDRESS;
   localparam logic [7:0] EV = mcr_pkg::EXC_VALUE;
   localparam logic [15:0] NW [5] = '{mcr_pkg::ADDR_OUTEN_WR, mcr_pkg::ADDR_MODE_WR, mcr_pkg::ADDR_SENSE_WR,
                                      mcr_pkg::ADDR_PROTO_WR, mcr_pkg::ADDR_ORIGIN_WR};
   localparam logic [15:0] NR [5] = '{mcr_pkg::ADDR_OUTEN_RD, mcr_pkg::ADDR_MODE_RD, mcr_pkg::ADDR_SENSE_RD,
                                      mcr_pkg::ADDR_PROTO_RD, mcr_pkg::ADDR_ORIGIN_RD};
   localparam logic [15:0] MA [3] = '{mcr_pkg::ADDR_MEAS_CURR, mcr_pkg::ADDR_MEAS_VOLT, mcr_pkg::ADDR_MEAS_PWR};
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [15:0] hard_flags = 16'h0000;
   logic [15:0] soft_flags = 16'h0000;
   logic [3:0]  regulation = 4'h0;
   logic [63:0] full_status = 64'h0;
   logic [31:0] meas [3] = '{32'h0, 32'h0, 32'h0};
   logic        req_valid, rsp_valid, output_enable, change_guard, defaults_recall;
   logic [7:0]  req_func, req_bytes, rsp_exception;
   logic [15:0] req_addr, req_count, regulation_mode, sense_config, protocol_select, target_origin;
   logic [63:0] req_data, rsp_data;
   logic [2:0]  rsp_count;
   logic [15:0] nport [5];
   int          num_errors = 0;
   int          checks_done = 0;
   int          seed = 35;
   always #10 clock = ~clock;
   assign nport[0] = {15'h0, output_enable};
   assign nport[1] = regulation_mode;
   assign nport[2] = sense_config;
   assign nport[3] = protocol_select;
   assign nport[4] = target_origin;
   mcr_bank u_dut (.clock_i(clock), .reset_n_i(reset_n), .req_valid_i(req_valid), .req_func_i(req_func),
      .req_addr_i(req_addr), .req_count_i(req_count), .req_bytes_i(req_bytes), .req_data_i(req_data),
      .hard_flags_i(hard_flags), .soft_flags_i(soft_flags), .regulation_i(regulation),
      .full_status_i(full_status), .measured_current_i(meas[0]), .measured_voltage_i(meas[1]),
      .measured_power_i(meas[2]), .rsp_valid_o(rsp_valid), .rsp_exception_o(rsp_exception),
      .rsp_count_o(rsp_count), .rsp_data_o(rsp_data), .output_enable_o(output_enable),
      .regulation_mode_o(regulation_mode), .change_guard_o(change_guard), .sense_config_o(sense_config),
      .protocol_select_o(protocol_select), .target_origin_o(target_origin), .defaults_recall_o(defaults_recall));
   mcr_master_model u_master (.clock_i(clock), .req_valid_o(req_valid), .req_func_o(req_func),
      .req_addr_o(req_addr), .req_count_o(req_count), .req_bytes_o(req_bytes), .req_data_o(req_data),
      .rsp_valid_i(rsp_valid), .rsp_exception_i(rsp_exception), .rsp_count_i(rsp_count), .rsp_data_i(rsp_data));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // answer comes exactly one cycle after the request, so no wait loop is needed here
   task automatic xfer(input logic [7:0] func, input logic [15:0] addr, input logic [15:0] count,
                       input logic [7:0] bytes, input logic [63:0] data, input logic [7:0] exp_exc,
                       output logic [63:0] rdata);
      logic       got;
      logic [7:0] exc;
      logic [2:0] cnt;
      u_master.transact(func, addr, count, bytes, data, got, exc, cnt, rdata);
      check(got, 1'b1, "answer pulse");
      check(exc, exp_exc, "exception code");
      check(cnt, (exp_exc == OK) ? count[2:0] : 3'h0, "answer count");
   endtask
   function automatic logic [15:0] ques_exp(input logic [15:0] h, input logic [15:0] s, input logic [3:0] r);
      logic [15:0] q;
      q = {h[15:13], 2'b00, r, h[3], h[2], h[1], s[2], s[1], s[0], h[0]};
      q[11] = |q[3:1];
      q[12] = q[0] | (|q[6:4]);
      return q;
   endfunction
   initial begin
      repeat (50000) @(posedge clock);
      num_errors++;
      final_report();
   end
   initial begin
      logic [63:0] rd;
      logic [31:0] v;
      logic [31:0] wv [13];
      logic [15:0] n;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      #1;
      check({output_enable, change_guard, defaults_recall, regulation_mode}, 19'h0, "reset outputs");
      for (int i = 0; i < mcr_pkg::NUM_WIDE; i++) begin
         v = $random(seed);
         wv[i] = v;
         xfer(RD, mcr_pkg::WIDE_RD[i], 16'h2, 8'h0, 64'h0, OK, rd);
         check(rd, 64'h0, "wide reset value");
         xfer(W2, mcr_pkg::WIDE_WR[i], 16'h2, 8'h4, {32'h0, v}, OK, rd);
         check(rd, {32'h0, v}, "write echo");
         xfer(RD, mcr_pkg::WIDE_WR[i], 16'h2, 8'h0, 64'h0, EA, rd);
         xfer(W2, mcr_pkg::WIDE_RD[i], 16'h2, 8'h4, {32'h0, ~v}, EA, rd);
         xfer(RD, mcr_pkg::WIDE_RD[i], 16'h2, 8'h0, 64'h0, OK, rd);
         check(rd, {32'h0, v}, "wide read-back");
      end
      for (int i = 0; i < 5; i++) begin
         n = 16'($random(seed));
         if (i == 0)
            n = {15'h0, n[0]};
         xfer(W1, NW[i], 16'h1, 8'h2, {48'h0, n}, OK, rd);
         check(nport[i], n, "setting output");
         xfer(RD, NR[i], 16'h1, 8'h0, 64'h0, OK, rd);
         check(rd, {48'h0, n}, "setting read-back");
         xfer(RD, NR[i], 16'h2, 8'h0, 64'h0, EA, rd);
      end
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         {hard_flags, soft_flags} <= (k == 0) ? 32'hFFFF_FFFF : $random(seed);
         v = $random(seed);
         regulation <= v[3:0];
         full_status <= {$random(seed), $random(seed)};
         for (int j = 0; j < 3; j++)
            meas[j] <= $random(seed);
         xfer(RD, mcr_pkg::ADDR_QUES_STATUS, 16'h2, 8'h0, 64'h0, OK, rd);
         check(rd, {48'h0, ques_exp(hard_flags, soft_flags, regulation)}, "questionable word");
         xfer(RD, mcr_pkg::ADDR_QUES_STATUS, 16'h2, 8'h0, 64'h0, OK, rd);
         check(rd, {48'h0, ques_exp(hard_flags, soft_flags, regulation)}, "questionable reread");
         xfer(W1, mcr_pkg::ADDR_QUES_STATUS, 16'h1, 8'h2, 64'h1, EA, rd);
         xfer(RD, mcr_pkg::ADDR_FULL_STATUS, 16'h4, 8'h0, 64'h0, OK, rd);
         check(rd, full_status, "full status");
         xfer(RD, mcr_pkg::ADDR_FULL_STATUS, 16'h2, 8'h0, 64'h0, EA, rd);
         for (int j = 0; j < 3; j++) begin
            xfer(RD, MA[j], 16'h2, 8'h0, 64'h0, OK, rd);
            check(rd, {32'h0, meas[j]}, "measurement");
            xfer(W2, MA[j], 16'h2, 8'h4, 64'h1, EA, rd);
         end
      end
      // refused requests must leave the stored value alone
      xfer(RD, mcr_pkg::WIDE_RD[0], 16'h0, 8'h0, 64'h0, EV, rd);
      xfer(RD, mcr_pkg::WIDE_RD[0], 16'h5, 8'h0, 64'h0, EV, rd);
      xfer(W2, mcr_pkg::WIDE_WR[0], 16'h2, 8'h3, 64'h1, EV, rd);
      xfer(W2, mcr_pkg::WIDE_WR[0], 16'h3, 8'h6, 64'h1, EV, rd);
      xfer(8'h01, mcr_pkg::WIDE_RD[0], 16'h2, 8'h0, 64'h0, EA, rd);
      xfer(W1, mcr_pkg::WIDE_WR[0], 16'h1, 8'h2, 64'h1, EA, rd);
      xfer(RD, mcr_pkg::WIDE_RD[0], 16'h2, 8'h0, 64'h0, OK, rd);
      check(rd, {32'h0, wv[0]}, "value after refusals");
      // lock: settings refused, output enable still reachable
      xfer(W1, mcr_pkg::ADDR_GUARD_WR, 16'h1, 8'h2, 64'h1, OK, rd);
      check(change_guard, 1'b1, "lock output");
      xfer(RD, mcr_pkg::ADDR_GUARD_RD, 16'h1, 8'h0, 64'h0, OK, rd);
      check(rd, 64'h1, "lock read-back");
      xfer(W2, mcr_pkg::WIDE_WR[1], 16'h2, 8'h4, {32'h0, ~wv[1]}, OK, rd);
      xfer(RD, mcr_pkg::WIDE_RD[1], 16'h2, 8'h0, 64'h0, OK, rd);
      check(rd, {32'h0, wv[1]}, "locked set-point");
      n = regulation_mode;
      xfer(W1, mcr_pkg::ADDR_MODE_WR, 16'h1, 8'h2, {48'h0, ~n}, OK, rd);
      check(regulation_mode, n, "locked mode");
      n = {15'h0, ~output_enable};
      xfer(W1, mcr_pkg::ADDR_OUTEN_WR, 16'h1, 8'h2, {48'h0, n}, OK, rd);
      check(output_enable, n[0], "output enable under lock");
      xfer(W1, mcr_pkg::ADDR_GUARD_WR, 16'h1, 8'h2, 64'h0, OK, rd);
      check(change_guard, 1'b0, "unlock");
      xfer(W1, mcr_pkg::ADDR_RECALL_WR, 16'h1, 8'h2, 64'h1, OK, rd);
      check(defaults_recall, 1'b1, "recall pulse");
      @(posedge clock);
      #1;
      check(defaults_recall, 1'b0, "recall pulse end");
      xfer(RD, mcr_pkg::ADDR_RECALL_WR, 16'h1, 8'h0, 64'h0, EA, rd);
      final_report();
   end
endmodule
`default_nettype wire
